// >>> bbrc_pkg.sv
// shared constants, carriers and decode functions for the rate and irq-pin config bank
`default_nettype none
package bbrc_pkg;

    // register offsets and reset values
    localparam logic [7:0] ADDR_RATE = 8'h04;
    localparam logic [7:0] ADDR_PIN = 8'h05;
    localparam logic [2:0] RATE_RESET = 3'h0;
    localparam logic [1:0] PIN_RESET = 2'h1;

    // field positions and widths
    localparam int CW_BIT = 2;
    localparam int DR_BIT = 1;
    localparam int SR_BIT = 0;
    localparam int RATE_W = 3;
    localparam int PIN_W = 2;
    localparam int REG_W = 8;
    localparam int HALF_W = 32;
    localparam int CODE_W = 64;

    // rate field patterns that the host must never write
    localparam logic [2:0] BAD_001 = 3'h1;
    localparam logic [2:0] BAD_010 = 3'h2;
    localparam logic [2:0] BAD_011 = 3'h3;
    localparam logic [2:0] BAD_111 = 3'h7;

    // irq pin drive methods
    localparam logic [1:0] PIN_OPEN_SOURCE = 2'h3;
    localparam logic [1:0] PIN_OPEN_DRAIN = 2'h2;
    localparam logic [1:0] PIN_CMOS = 2'h1;
    localparam logic [1:0] PIN_CMOS_INV = 2'h0;

    // decoded figures
    localparam logic [1:0] BITS_NORMAL = 2'h1;
    localparam logic [1:0] BITS_DOUBLE = 2'h2;
    localparam logic [3:0] OVS_6X = 4'h6;
    localparam logic [3:0] OVS_12X = 4'hC;

    // raw throughput class: 64-chip, 32 kbit/s, 62.5 kbit/s
    typedef enum logic [1:0] {RATE_64CHIP, RATE_32K, RATE_62K5} bbrc_rate_kind_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bbrc_req_type;

    typedef struct packed {
        logic code_is_32;
        logic double_rate;
        logic [1:0] bits_per_code;
        logic [3:0] samples_per_chip;
        logic dual_code_en;
        bbrc_rate_kind_type rate_kind;
    } bbrc_cfg_type;

    localparam bbrc_cfg_type CFG_RESET = '{code_is_32: 1'h0, double_rate: 1'h0,
        bits_per_code: BITS_NORMAL, samples_per_chip: OVS_6X, dual_code_en: 1'h0,
        rate_kind: RATE_64CHIP};

    typedef struct packed {
        logic [2:0] rate_field;
        logic [1:0] pin_sel;
        logic [7:0] rdata;
        logic rvalid;
        bbrc_cfg_type cfg;
        logic [31:0] code_a;
        logic [31:0] code_b;
        logic invalid;
    } bbrc_state_type;

    typedef struct packed {
        logic out;
        logic oe_n;
    } bbrc_pin_type;

    // rate field to effective mode; ignored bits are masked here
    function automatic bbrc_cfg_type decode(input logic [2:0] f);
        bbrc_cfg_type c;
        c.code_is_32 = f[CW_BIT]; // see RULE1
        c.double_rate = f[CW_BIT] & f[DR_BIT]; // see RULE3
        c.bits_per_code = c.double_rate ? BITS_DOUBLE : BITS_NORMAL; // see RULE2
        c.samples_per_chip = (f[CW_BIT] & ~f[DR_BIT] & f[SR_BIT]) ? OVS_12X : OVS_6X; // see RULE7
        c.dual_code_en = f[CW_BIT] & ~f[DR_BIT]; // see RULE6 see RULE8
        if (!f[CW_BIT]) begin
            c.rate_kind = RATE_64CHIP;
        end else if (f[DR_BIT]) begin
            c.rate_kind = RATE_62K5; // see RULE5
        end else begin
            c.rate_kind = RATE_32K;
        end
        return c;
    endfunction : decode

    function automatic logic is_invalid(input logic [2:0] f);
        return (f == BAD_001) || (f == BAD_010) || (f == BAD_011) || (f == BAD_111);
    endfunction : is_invalid

endpackage : bbrc_pkg
`default_nettype wire

// >>> bbrc_irq_pin.sv
// irq pin driver: maps the pending level onto the selected drive method
`timescale 1ns/1ns
`default_nettype none
module bbrc_irq_pin (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control
    input wire logic [1:0] pin_sel,
    input wire logic irq_pending,
    // pin, enable low while driving
    output logic irq_out,
    output logic irq_oe_n
);

    bbrc_pkg::bbrc_pin_type state_reg;
    bbrc_pkg::bbrc_pin_type state_next;

    // drive method decode; pending already folds in the enables upstream
    always_comb begin
        state_next = state_reg;
        case (pin_sel)
            bbrc_pkg::PIN_OPEN_SOURCE: begin // see RULE11
                state_next.out = 1'h1;
                state_next.oe_n = ~irq_pending; // see RULE15
            end
            bbrc_pkg::PIN_OPEN_DRAIN: begin // see RULE11
                state_next.out = 1'h0;
                state_next.oe_n = ~irq_pending;
            end
            bbrc_pkg::PIN_CMOS: begin // see RULE12
                state_next.out = irq_pending;
                state_next.oe_n = 1'h0;
            end
            default: begin // see RULE12
                state_next.out = ~irq_pending;
                state_next.oe_n = 1'h0;
            end
        endcase
    end

    // reset gives cmos, deasserted, matching the pin register default
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= '{out: 1'h0, oe_n: 1'h0};
        end else begin
            state_reg <= state_next;
        end
    end

    assign irq_out = state_reg.out;
    assign irq_oe_n = state_reg.oe_n;

    property p_open_source;
        @(posedge clk) disable iff (!rst_n)
        $past(pin_sel) == bbrc_pkg::PIN_OPEN_SOURCE |->
            (irq_oe_n == !$past(irq_pending)) && irq_out;
    endproperty
    a_open_source: assert property (p_open_source) // see RULE11
        else $error("open source drive wrong");

    property p_open_drain;
        @(posedge clk) disable iff (!rst_n)
        $past(pin_sel) == bbrc_pkg::PIN_OPEN_DRAIN |->
            (irq_oe_n == !$past(irq_pending)) && !irq_out;
    endproperty
    a_open_drain: assert property (p_open_drain) // see RULE11
        else $error("open drain drive wrong");

    property p_cmos;
        @(posedge clk) disable iff (!rst_n)
        $past(pin_sel) == bbrc_pkg::PIN_CMOS |-> !irq_oe_n && irq_out == $past(irq_pending);
    endproperty
    a_cmos: assert property (p_cmos) // see RULE12
        else $error("cmos drive wrong");

    property p_cmos_inv;
        @(posedge clk) disable iff (!rst_n)
        $past(pin_sel) == bbrc_pkg::PIN_CMOS_INV |->
            !irq_oe_n && irq_out != $past(irq_pending);
    endproperty
    a_cmos_inv: assert property (p_cmos_inv) // see RULE12
        else $error("inverted cmos drive wrong");

endmodule : bbrc_irq_pin
`default_nettype wire

// >>> bbrc_config.sv
// rate control and irq pin config registers with decoded baseband settings
// Notes on behaviour
// RULE1: code width bit one selects 32 chips
// RULE2: double rate gives two bits per code
// RULE3: double rate only honoured in 32-chip mode
// RULE4: double rate splits 64-chip code into halves
// RULE5: throughput 62.5k double, 32k normal, 32-chip
// RULE6: normal 32-chip rate allows two correlation codes
// RULE7: sample bit one means twelve-times oversampling
// RULE8: sample bit ignored unless 32-chip normal rate
// RULE9: host never writes rate patterns 001,010,011,111
// RULE10: host writes zero into reserved upper bits
// RULE11: select 11 open source, 10 open drain
// RULE12: select 01 cmos, 00 inverted cmos
// RULE13: 32-chip width enables half, rate, sample fields
// RULE14: half select picks upper or lower 32 chips
// RULE15: pin asserted while enabled interrupt is pending
`timescale 1ns/1ns
`default_nettype none
module bbrc_config (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register access from the serial interface engine
    input wire bbrc_pkg::bbrc_req_type reg_req,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // code register contents and half select from the tx/rx control register
    input wire logic [63:0] pn_code,
    input wire logic code_half_select,
    // interrupt level from the interrupt sources, already masked
    input wire logic irq_pending,
    // decoded settings towards the baseband
    output bbrc_pkg::bbrc_cfg_type cfg,
    output logic [31:0] code_a,
    output logic [31:0] code_b,
    output logic cfg_invalid,
    // irq pin, enable low while driving
    output logic irq_out,
    output logic irq_oe_n
);

    bbrc_pkg::bbrc_state_type state_reg;
    bbrc_pkg::bbrc_state_type state_next;
    logic [31:0] pn_lo;
    logic [31:0] pn_hi;

    // code halves as the correlators see them
    assign pn_lo = pn_code[bbrc_pkg::HALF_W-1:0];
    assign pn_hi = pn_code[bbrc_pkg::CODE_W-1:bbrc_pkg::HALF_W];

    // register access, decode and code lane steering
    always_comb begin
        state_next = state_reg;
        state_next.rvalid = 1'h0;
        // only implemented bits are stored, so reserved bits read back zero
        if (reg_req.wr) begin
            case (reg_req.addr)
                bbrc_pkg::ADDR_RATE: begin
                    state_next.rate_field = reg_req.wdata[bbrc_pkg::RATE_W-1:0]; // see RULE10
                end
                bbrc_pkg::ADDR_PIN: begin
                    state_next.pin_sel = reg_req.wdata[bbrc_pkg::PIN_W-1:0]; // see RULE10
                end
                default: begin
                end
            endcase
        end
        // a read in the same cycle as a write returns the old value
        if (reg_req.rd) begin
            state_next.rvalid = 1'h1;
            case (reg_req.addr)
                bbrc_pkg::ADDR_RATE: begin
                    state_next.rdata = bbrc_pkg::REG_W'(state_reg.rate_field);
                end
                bbrc_pkg::ADDR_PIN: begin
                    state_next.rdata = bbrc_pkg::REG_W'(state_reg.pin_sel);
                end
                default: begin
                    state_next.rdata = 8'h00;
                end
            endcase
        end
        // decode follows the new field so cfg changes together with it
        state_next.cfg = bbrc_pkg::decode(state_next.rate_field); // see RULE1 see RULE13
        // a bad pattern is still stored; the flag lets firmware notice it
        state_next.invalid = bbrc_pkg::is_invalid(state_next.rate_field); // see RULE9
        if (!state_next.cfg.code_is_32 || state_next.cfg.double_rate) begin
            // 64-chip or double rate: low half on lane a, high half on lane b
            state_next.code_a = pn_lo; // see RULE4
            state_next.code_b = pn_hi;
        end else if (code_half_select) begin
            // normal 32-chip: selected half first, the other as second code
            state_next.code_a = pn_hi; // see RULE14 see RULE6
            state_next.code_b = pn_lo;
        end else begin
            state_next.code_a = pn_lo; // see RULE14
            state_next.code_b = pn_hi;
        end
    end

    // one register for all state; reset loads the documented defaults
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= '0;
            state_reg.rate_field <= bbrc_pkg::RATE_RESET;
            state_reg.pin_sel <= bbrc_pkg::PIN_RESET;
            state_reg.cfg <= bbrc_pkg::CFG_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign reg_rdata = state_reg.rdata;
    assign reg_rvalid = state_reg.rvalid;
    assign cfg = state_reg.cfg;
    assign code_a = state_reg.code_a;
    assign code_b = state_reg.code_b;
    assign cfg_invalid = state_reg.invalid;

    // pin driver keeps its own flip-flops so the pin outputs stay registered
    bbrc_irq_pin u_irq_pin (
        .clk(clk),
        .rst_n(rst_n),
        .pin_sel(state_reg.pin_sel),
        .irq_pending(irq_pending), // see RULE15
        .irq_out(irq_out),
        .irq_oe_n(irq_oe_n)
    );

    // decode checks: registered settings against the stored rate field, bits per code against double_rate
    property p_code_width;
        @(posedge clk) disable iff (!rst_n)
        cfg.code_is_32 == state_reg.rate_field[bbrc_pkg::CW_BIT];
    endproperty
    a_code_width: assert property (p_code_width) // see RULE1
        else $error("code width decode wrong");

    property p_bits_per_code;
        @(posedge clk) disable iff (!rst_n)
        cfg.bits_per_code == (cfg.double_rate ? 2'h2 : 2'h1);
    endproperty
    a_bits_per_code: assert property (p_bits_per_code) // see RULE2
        else $error("bits per code wrong");

    property p_ddr_only_32;
        @(posedge clk) disable iff (!rst_n)
        cfg.double_rate == (state_reg.rate_field[bbrc_pkg::CW_BIT]
            && state_reg.rate_field[bbrc_pkg::DR_BIT]);
    endproperty
    a_ddr_only_32: assert property (p_ddr_only_32) // see RULE3
        else $error("double rate honoured outside 32-chip mode");

    // lane checks: lanes lag the code inputs by one edge, cfg does not
    property p_ddr_split;
        @(posedge clk) disable iff (!rst_n)
        cfg.double_rate && $past(cfg.double_rate) |->
            code_a == $past(pn_lo) && code_b == $past(pn_hi);
    endproperty
    a_ddr_split: assert property (p_ddr_split) // see RULE4
        else $error("double rate code halves wrong");

    property p_rate_kind;
        @(posedge clk) disable iff (!rst_n)
        cfg.code_is_32 |->
            cfg.rate_kind == (cfg.double_rate ? bbrc_pkg::RATE_62K5 : bbrc_pkg::RATE_32K);
    endproperty
    a_rate_kind: assert property (p_rate_kind) // see RULE5
        else $error("throughput class wrong");

    property p_dual_code;
        @(posedge clk) disable iff (!rst_n)
        cfg.dual_code_en == (cfg.code_is_32 && !cfg.double_rate);
    endproperty
    a_dual_code: assert property (p_dual_code) // see RULE6
        else $error("dual code enable wrong");

    property p_oversample;
        @(posedge clk) disable iff (!rst_n)
        (cfg.samples_per_chip == 4'hC) == (cfg.dual_code_en
            && state_reg.rate_field[bbrc_pkg::SR_BIT]);
    endproperty
    a_oversample: assert property (p_oversample) // see RULE7 see RULE8
        else $error("oversampling decode wrong");

    property p_half_select;
        @(posedge clk) disable iff (!rst_n)
        cfg.dual_code_en && $past(cfg.dual_code_en) && $past(code_half_select) |->
            code_a == $past(pn_hi);
    endproperty
    a_half_select: assert property (p_half_select) // see RULE14
        else $error("upper half not selected");

    property p_half_lower;
        @(posedge clk) disable iff (!rst_n)
        cfg.dual_code_en && !$past(code_half_select) |->
            code_a == $past(pn_lo) && code_b == $past(pn_hi);
    endproperty
    a_half_lower: assert property (p_half_lower) // see RULE14
        else $error("lower half not selected");

    property p_second_code;
        @(posedge clk) disable iff (!rst_n)
        cfg.dual_code_en && $past(code_half_select) |->
            code_b == $past(pn_lo);
    endproperty
    a_second_code: assert property (p_second_code) // see RULE6
        else $error("second correlation code wrong");

    property p_invalid_flag;
        @(posedge clk) disable iff (!rst_n)
        cfg_invalid == (state_reg.rate_field inside {3'h1, 3'h2, 3'h3, 3'h7});
    endproperty
    a_invalid_flag: assert property (p_invalid_flag) // see RULE9
        else $error("invalid pattern flag wrong");

    property p_reserved_zero;
        @(posedge clk) disable iff (!rst_n)
        reg_req.rd && reg_req.addr == bbrc_pkg::ADDR_RATE |=>
            reg_rvalid && reg_rdata == {5'h00, $past(state_reg.rate_field)};
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) // see RULE10
        else $error("rate readback wrong");

endmodule : bbrc_config
`default_nettype wire

// >>> bbrc_host_model.sv
// host microcontroller model: issues strobe register accesses towards the config bank
`timescale 1ns/1ns
`default_nettype none
module bbrc_host_model (
    // clock
    input wire logic clk,
    // register access
    output var bbrc_pkg::bbrc_req_type reg_req,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid
);
    // idle bus shows a changing pattern so a stale value never looks valid
    initial begin
        reg_req = '{addr: 8'h5a, wdata: 8'ha5, wr: 1'b0, rd: 1'b0};
    end

    // release: strobes low, address and data inverted
    task automatic release_bus;
        reg_req <= '{addr: ~reg_req.addr, wdata: ~reg_req.wdata, wr: 1'b0, rd: 1'b0};
    endtask : release_bus

    // one-cycle write strobe; a legal write keeps the host's own obligations
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input bit legal);
        logic [7:0] v;
        v = d;
        if (legal && a == bbrc_pkg::ADDR_RATE && d[2:0] inside {3'h1, 3'h2, 3'h3, 3'h7}) begin
            return;
        end
        if (legal) begin
            v = (a == bbrc_pkg::ADDR_RATE) ? (d & 8'h07) : (d & 8'h03);
        end
        @(negedge clk);
        reg_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(negedge clk);
        release_bus();
    endtask : wr

    // one-cycle read strobe, then a bounded wait for the answer
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output bit ok);
        ok = 1'b0;
        d = 8'h00;
        @(negedge clk);
        reg_req <= '{addr: a, wdata: ~reg_req.wdata, wr: 1'b0, rd: 1'b1};
        @(negedge clk);
        release_bus();
        for (int i = 0; i < 3 && !ok; i++) begin
            if (reg_rvalid === 1'b1) begin
                ok = 1'b1;
                d = reg_rdata;
            end else begin
                @(negedge clk);
            end
        end
    endtask : rd
endmodule : bbrc_host_model
`default_nettype wire

// >>> tb_top.sv
// self-checking bench for the rate control and irq pin config bank
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [63:0] pn_code = 64'h0123_4567_89ab_cdef;
    logic half_sel = 1'b0;
    logic irq_pending = 1'b0;
    bbrc_pkg::bbrc_req_type reg_req;
    logic [7:0] reg_rdata;
    logic reg_rvalid;
    bbrc_pkg::bbrc_cfg_type cfg;
    logic [31:0] code_a;
    logic [31:0] code_b;
    logic cfg_invalid;
    logic irq_out;
    logic irq_oe_n;
    int errors = 0;
    int compares = 0;

    // 25 MHz clock
    always #20 clk = ~clk;

    bbrc_host_model host_u (.clk(clk), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid));

    bbrc_config dut_u (.clk(clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .pn_code(pn_code), .code_half_select(half_sel),
        .irq_pending(irq_pending), .cfg(cfg), .code_a(code_a), .code_b(code_b),
        .cfg_invalid(cfg_invalid), .irq_out(irq_out), .irq_oe_n(irq_oe_n));

    task automatic test_done;
        if (errors == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done

    task automatic bad(input string msg);
        errors++;
        $display("Error at %0t: %s", $time, msg);
    endtask : bad

    // compare tasks, one per kind of result
    task automatic chk_reg(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) bad($sformatf("register read %h, expected %h", g, e));
    endtask : chk_reg

    task automatic chk_cfg(input bbrc_pkg::bbrc_cfg_type g, input bbrc_pkg::bbrc_cfg_type e);
        compares++;
        if (g !== e) bad($sformatf("decoded settings %h, expected %h", g, e));
    endtask : chk_cfg

    task automatic chk_code(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) bad($sformatf("code lane %h, expected %h", g, e));
    endtask : chk_code

    task automatic chk_pin(input logic g, input logic e);
        compares++;
        if (g !== e) bad($sformatf("flag or pin %b, expected %b", g, e));
    endtask : chk_pin

    // expected settings worked out field by field
    function automatic bbrc_pkg::bbrc_cfg_type exp_cfg(input logic [2:0] f);
        bbrc_pkg::bbrc_cfg_type c;
        c.code_is_32 = f[2];
        c.double_rate = f[2] && f[1];
        c.bits_per_code = c.double_rate ? 2'h2 : 2'h1;
        c.samples_per_chip = (f == 3'h5) ? 4'hc : 4'h6;
        c.dual_code_en = (f[2:1] == 2'h2);
        c.rate_kind = !f[2] ? bbrc_pkg::RATE_64CHIP
            : (f[1] ? bbrc_pkg::RATE_62K5 : bbrc_pkg::RATE_32K);
        return c;
    endfunction : exp_cfg

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        bit ok;
        host_u.rd(a, d, ok);
        // a missing answer ends the run rather than comparing stale data
        if (!ok) begin
            bad("no read answer");
            test_done();
        end else begin
            chk_reg(d, e);
        end
    endtask : rd_chk

    // defaults after reset, cmos pin idle low
    task automatic t_reset;
        rd_chk(bbrc_pkg::ADDR_RATE, 8'h00);
        rd_chk(bbrc_pkg::ADDR_PIN, 8'h01);
        chk_cfg(cfg, exp_cfg(3'h0));
        chk_pin(irq_oe_n, 1'b0);
        chk_pin(irq_out, 1'b0);
    endtask : t_reset

    // every rate pattern, both half selects, invalid ones sent on purpose
    task automatic t_rate;
        logic [2:0] f;
        logic inv;
        logic dual;
        for (int i = 0; i < 8; i++) begin
            f = i[2:0];
            inv = f inside {3'h1, 3'h2, 3'h3, 3'h7};
            dual = (f[2:1] == 2'h2);
            host_u.wr(bbrc_pkg::ADDR_RATE, {5'h00, f}, !inv);
            for (int h = 0; h < 2; h++) begin
                half_sel = h[0];
                repeat (2) @(negedge clk);
                chk_cfg(cfg, exp_cfg(f));
                chk_pin(cfg_invalid, inv);
                chk_code(code_a, (dual && h[0]) ? pn_code[63:32] : pn_code[31:0]);
                chk_code(code_b, (dual && h[0]) ? pn_code[31:0] : pn_code[63:32]);
            end
            rd_chk(bbrc_pkg::ADDR_RATE, {5'h00, f});
        end
    endtask : t_rate

    // reserved bits dropped, unmapped address ignored and read as zero
    task automatic t_reserved;
        host_u.wr(bbrc_pkg::ADDR_RATE, 8'hfc, 1'b0);
        rd_chk(bbrc_pkg::ADDR_RATE, 8'h04);
        host_u.wr(bbrc_pkg::ADDR_PIN, 8'hfe, 1'b0);
        rd_chk(bbrc_pkg::ADDR_PIN, 8'h02);
        host_u.wr(8'h06, 8'hff, 1'b0);
        rd_chk(8'h06, 8'h00);
        rd_chk(bbrc_pkg::ADDR_RATE, 8'h04);
        rd_chk(bbrc_pkg::ADDR_PIN, 8'h02);
    endtask : t_reserved

    // every drive method with the pending level both ways
    task automatic t_pin;
        logic e_oe_n;
        logic e_out;
        for (int s = 0; s < 4; s++) begin
            host_u.wr(bbrc_pkg::ADDR_PIN, {6'h00, s[1:0]}, 1'b1);
            for (int p = 0; p < 2; p++) begin
                irq_pending = p[0];
                repeat (3) @(negedge clk);
                // open source and open drain float while deasserted
                e_oe_n = (s >= 2) ? !p[0] : 1'b0;
                case (s)
                    3: e_out = 1'b1;
                    2: e_out = 1'b0;
                    1: e_out = p[0];
                    default: e_out = !p[0];
                endcase
                chk_pin(irq_oe_n, e_oe_n);
                if (!e_oe_n) chk_pin(irq_out, e_out);
            end
        end
    endtask : t_pin

    // main sequence
    initial begin
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        t_reset();
        t_rate();
        t_reserved();
        t_pin();
        test_done();
    end

    // a hang counts as a mismatch
    initial begin
        repeat (5000) @(posedge clk);
        bad("run did not finish");
        test_done();
    end
endmodule : tb_top
`default_nettype wire
